// ==== pkg/charger_ctrl_pkg.sv ====
// constants, field layouts and state types of the charger control registers
package charger_ctrl_pkg;

  localparam logic [7:0] ADDR_CURRENT_THERMAL = 8'h0b;
  localparam logic [7:0] ADDR_ENABLE_DETECT = 8'h0c;

  localparam logic [7:0] RST_CURRENT_THERMAL = 8'h6b;
  // enable/detect default; the charger_on bit is filled from the pin
  localparam logic [7:0] RST_ENABLE_DETECT = 8'h84;
  localparam int CHARGER_ON_BIT = 4;

  localparam int CLK_MHZ = 250;
  localparam int HOLD_TIME_MS = 63;
  localparam int HOLD_CYCLES = HOLD_TIME_MS * CLK_MHZ * 1000;
  localparam int HOLD_CNT_W = 24;

  typedef struct packed {
    logic reserved;
    logic [1:0] topoff_percent_sel;
    logic [2:0] fast_charge_current_sel;
    logic [1:0] die_temp_threshold_sel;
  } current_thermal_t;

  typedef struct packed {
    logic thermistor_input_on;
    logic presence_result_mask;
    logic presence_source_sel;
    logic charger_on;
    logic enable_pin_mask;
    logic [2:0] termination_current_sel;
  } enable_detect_t;

  typedef struct packed {
    current_thermal_t ctl_a;
    enable_detect_t ctl_b;
    logic [7:0] rdata;
    logic rd_valid;
    logic present_q;
    logic battery_present;
    logic charge_allowed;
    logic power_on_out;
    logic power_on_oe;
  } ctrl_state_t;

  typedef struct packed {
    logic [HOLD_CNT_W-1:0] count;
    logic busy;
  } hold_state_t;

endpackage : charger_ctrl_pkg

// ==== rtl/power_on_hold_timer.sv ====
// one-shot timer that holds the power-on output released for a fixed time
`timescale 1ns/1ps
module power_on_hold_timer #(
  parameter int CYCLES = charger_ctrl_pkg::HOLD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic abort,
  output logic busy
);

  localparam logic [charger_ctrl_pkg::HOLD_CNT_W-1:0] LAST =
    charger_ctrl_pkg::HOLD_CNT_W'(CYCLES - 1);

  charger_ctrl_pkg::hold_state_t st_r;
  charger_ctrl_pkg::hold_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (abort) begin
      st_nxt = '0;
    end else if (start) begin
      // a new detection restarts the full hold
      st_nxt.busy = 1'b1;
      st_nxt.count = LAST;
    end else if (st_r.busy) begin
      if (st_r.count == '0) begin
        st_nxt.busy = 1'b0;
      end else begin
        st_nxt.count = st_r.count - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = st_r.busy;

endmodule : power_on_hold_timer

// ==== rtl/charger_control_registers.sv ====
// charger control registers behind the serial-bus register port
// Operation
// - two-bit die temperature threshold, default 11
// - three-bit fast-charge current code, default 010
// - two-bit top-off percentage of fast charge, default 11
// - three-bit termination current code, default 100
// - pin mask bit3: 0 follows pin, 1 ignores
// - unmasked: charger bit mirrors pin, writes ignored
// - masked: host writes charger on/off bit
// - bit5 picks internal detector or thermistor presence
// - unmasked detection gates charging, holds output 63ms
// - masked detection affects neither output nor charging
// - bit7 turns thermistor input off or on
`timescale 1ns/1ps
module charger_control_registers #(
  parameter int HOLD_CYCLES = charger_ctrl_pkg::HOLD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic usb_valid,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic external_enable_pin,
  input wire logic internal_presence,
  input wire logic thermistor_presence,
  input wire logic power_on_request,
  output logic [1:0] die_temp_threshold_sel,
  output logic [2:0] fast_charge_current_sel,
  output logic [1:0] topoff_percent_sel,
  output logic [2:0] termination_current_sel,
  output logic charger_on,
  output logic presence_source_sel,
  output logic thermistor_input_on,
  output logic battery_present,
  output logic charge_allowed,
  output logic power_on_output_out,
  output logic power_on_output_oe
);

  charger_ctrl_pkg::ctrl_state_t st_r;
  charger_ctrl_pkg::ctrl_state_t st_nxt;
  logic hold_busy;
  logic presence_sel;
  logic hold_start;

  function automatic logic [7:0] reg_read(
    input logic [7:0] addr,
    input charger_ctrl_pkg::current_thermal_t a,
    input charger_ctrl_pkg::enable_detect_t b
  );
    logic [7:0] d;
    d = 8'h00;
    case (addr)
      charger_ctrl_pkg::ADDR_CURRENT_THERMAL: d = a;
      charger_ctrl_pkg::ADDR_ENABLE_DETECT: d = b;
      default: d = 8'h00;
    endcase
    return d;
  endfunction : reg_read

  // presence source and a rise of it, which starts the hold
  assign presence_sel = st_r.ctl_b.presence_source_sel ?
    thermistor_presence : internal_presence;
  assign hold_start = presence_sel && !st_r.present_q &&
    !st_r.ctl_b.presence_result_mask;

  power_on_hold_timer #(
    .CYCLES(HOLD_CYCLES)
  ) u_hold (
    .sys_clk(sys_clk),
    .reset(reset),
    .start(hold_start),
    .abort(st_r.ctl_b.presence_result_mask),
    .busy(hold_busy)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_valid = 1'b0;
    if (reset || !usb_valid) begin
      // power-on and usb-invalid share the same defaults
      st_nxt.ctl_a = charger_ctrl_pkg::RST_CURRENT_THERMAL;
      st_nxt.ctl_b = charger_ctrl_pkg::RST_ENABLE_DETECT;
      st_nxt.rdata = 8'h00;
    end else begin
      if (reg_wr && reg_addr == charger_ctrl_pkg::ADDR_CURRENT_THERMAL) begin
        st_nxt.ctl_a = reg_wdata;
      end
      if (reg_wr && reg_addr == charger_ctrl_pkg::ADDR_ENABLE_DETECT) begin
        st_nxt.ctl_b = reg_wdata;
      end
      if (reg_rd) begin
        st_nxt.rdata = reg_read(reg_addr, st_r.ctl_a, st_r.ctl_b);
        st_nxt.rd_valid = 1'b1;
      end
    end
    // the pin wins over any write while unmasked
    if (!st_nxt.ctl_b.enable_pin_mask) begin
      st_nxt.ctl_b.charger_on = external_enable_pin;
    end
    st_nxt.present_q = presence_sel;
    st_nxt.battery_present = presence_sel;
    // masked detection no longer blocks charging
    st_nxt.charge_allowed = st_r.ctl_b.charger_on &&
      (st_r.ctl_b.presence_result_mask || presence_sel);
    st_nxt.power_on_out = power_on_request;
    st_nxt.power_on_oe = !hold_busy ||
      st_r.ctl_b.presence_result_mask;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= '0;
      st_r.ctl_a <= charger_ctrl_pkg::RST_CURRENT_THERMAL;
      st_r.ctl_b <= charger_ctrl_pkg::RST_ENABLE_DETECT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign reg_rd_valid = st_r.rd_valid;
  assign die_temp_threshold_sel = st_r.ctl_a.die_temp_threshold_sel;
  assign fast_charge_current_sel = st_r.ctl_a.fast_charge_current_sel;
  assign topoff_percent_sel = st_r.ctl_a.topoff_percent_sel;
  assign termination_current_sel = st_r.ctl_b.termination_current_sel;
  assign charger_on = st_r.ctl_b.charger_on;
  assign presence_source_sel = st_r.ctl_b.presence_source_sel;
  assign thermistor_input_on = st_r.ctl_b.thermistor_input_on;
  assign battery_present = st_r.battery_present;
  assign charge_allowed = st_r.charge_allowed;
  assign power_on_output_out = st_r.power_on_out;
  assign power_on_output_oe = st_r.power_on_oe;

  property p_defaults_a;
    @(posedge sys_clk) disable iff (reset)
      !usb_valid |=> (st_r.ctl_a == 8'h6b && st_r.ctl_b.thermistor_input_on
        && st_r.ctl_b.termination_current_sel == 3'h4);
  endproperty
  a_defaults_a: assert property (p_defaults_a)
    else $error("defaults not restored while usb invalid");

  property p_pin_follow;
    @(posedge sys_clk) disable iff (reset)
      (usb_valid && !st_r.ctl_b.enable_pin_mask && !reg_wr) |=>
        (st_r.ctl_b.enable_pin_mask ||
          st_r.ctl_b.charger_on == $past(external_enable_pin));
  endproperty
  a_pin_follow: assert property (p_pin_follow)
    else $error("charger bit does not follow the pin");

  property p_host_on;
    @(posedge sys_clk) disable iff (reset)
      (usb_valid && reg_wr && reg_addr == 8'h0c && reg_wdata[3]) |=>
        st_r.ctl_b.charger_on == $past(reg_wdata[4]);
  endproperty
  a_host_on: assert property (p_host_on)
    else $error("masked charger bit not taken from host write");

  // presence follows the source bit held in the register
  property p_source;
    @(posedge sys_clk) disable iff (reset)
      1'b1 |=> battery_present == ($past(presence_source_sel) ?
        $past(thermistor_presence) : $past(internal_presence));
  endproperty
  a_source: assert property (p_source)
    else $error("presence taken from the wrong source");

  property p_write_a;
    @(posedge sys_clk) disable iff (reset)
      (usb_valid && reg_wr && reg_addr == 8'h0b) |=>
        (fast_charge_current_sel == $past(reg_wdata[4:2]) &&
         topoff_percent_sel == $past(reg_wdata[6:5]) &&
         die_temp_threshold_sel == $past(reg_wdata[1:0]));
  endproperty
  a_write_a: assert property (p_write_a)
    else $error("current/thermal fields not written");

  property p_read_back;
    @(posedge sys_clk) disable iff (reset)
      (usb_valid && reg_rd && !reg_wr && reg_addr == 8'h0c) |=>
        (reg_rd_valid && reg_rdata == $past(st_r.ctl_b));
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("enable/detect read back wrong");

  property p_mask_charge;
    @(posedge sys_clk) disable iff (reset)
      st_r.ctl_b.presence_result_mask |=>
        charge_allowed == $past(st_r.ctl_b.charger_on);
  endproperty
  a_mask_charge: assert property (p_mask_charge)
    else $error("masked detection still gates charging");

  property p_mask_drive;
    @(posedge sys_clk) disable iff (reset)
      st_r.ctl_b.presence_result_mask |=> power_on_output_oe;
  endproperty
  a_mask_drive: assert property (p_mask_drive)
    else $error("masked detection released the power-on output");

  sequence s_detect;
    hold_start ##1 !st_r.ctl_b.presence_result_mask
      ##1 !st_r.ctl_b.presence_result_mask;
  endsequence

  property p_hold;
    @(posedge sys_clk) disable iff (reset)
      s_detect |-> !power_on_output_oe;
  endproperty
  a_hold: assert property (p_hold)
    else $error("power-on output not released after detection");

  property p_no_presence;
    @(posedge sys_clk) disable iff (reset)
      (!st_r.ctl_b.presence_result_mask && !presence_sel) |=>
        !charge_allowed;
  endproperty
  a_no_presence: assert property (p_no_presence)
    else $error("charging allowed without a battery");

endmodule : charger_control_registers

// ==== verif/host_model.sv ====
// host side of the register port: one byte access at a time
`timescale 1ns/1ps
module host_model (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // idle bus shows inverted values so stale data never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v,
                    output logic ok);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    ok = reg_rd_valid;
    v = reg_rdata;
  endtask : rd
endmodule : host_model

// ==== verif/testbench.sv ====
// self-checking bench for the charger control registers
`timescale 1ns/1ps
module testbench;
  localparam int HOLD = 20;
  logic sys_clk, reset, usb_valid, pin, ipres, tpres, preq;
  logic [7:0] ra, wd, rdat, d;
  logic wr, rd, rv, ok, con, src, thon, bp, cal, po, oe;
  logic [1:0] dts, tps;
  logic [2:0] fcs, tcs;
  int bad_count = 0;
  int compares = 0;
  int n;
  charger_control_registers #(.HOLD_CYCLES(HOLD)) dut_u (
    .sys_clk(sys_clk), .reset(reset), .usb_valid(usb_valid),
    .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdat), .reg_rd_valid(rv), .external_enable_pin(pin),
    .internal_presence(ipres), .thermistor_presence(tpres),
    .power_on_request(preq), .die_temp_threshold_sel(dts),
    .fast_charge_current_sel(fcs), .topoff_percent_sel(tps),
    .termination_current_sel(tcs), .charger_on(con),
    .presence_source_sel(src), .thermistor_input_on(thon),
    .battery_present(bp), .charge_allowed(cal),
    .power_on_output_out(po), .power_on_output_oe(oe));
  host_model host_u (.sys_clk(sys_clk), .reg_rdata(rdat),
    .reg_rd_valid(rv), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, e);
  endtask : rchk
  task automatic t_defaults;
    rchk(8'h0b, 8'h6b);
    rchk(8'h0c, 8'h94);
    rchk(8'h0d, 8'h00);
    chk({3'h0, dts, fcs}, 8'h1a);
    chk({3'h0, tps, tcs}, 8'h1c);
    chk({6'h00, thon, con}, 8'h03);
    $display("defaults done");
  endtask : t_defaults
  task automatic t_fields;
    logic [7:0] tv[5] = '{8'h00, 8'hff, 8'h55, 8'haa, 8'h1c};
    logic [7:0] v;
    foreach (tv[i]) begin
      host_u.wr(8'h0b, tv[i]);
      rchk(8'h0b, tv[i]);
      chk({1'b0, tps, fcs, dts}, tv[i] & 8'h7f);
    end
    for (int i = 0; i < 8; i++) begin
      v = {i[1], 1'b0, i[0], 2'b01, i[2:0]};
      host_u.wr(8'h0c, v);
      rchk(8'h0c, v);
      chk({3'h0, thon, src, tcs}, {3'h0, v[7], v[5], v[2:0]});
    end
    $display("fields done");
  endtask : t_fields
  task automatic ecase(input logic [7:0] v, input logic p, input logic e);
    host_u.wr(8'h0c, v);
    pin = p;
    repeat (2) @(negedge sys_clk);
    chk({7'h00, con}, {7'h00, e});
  endtask : ecase
  task automatic t_enable;
    ecase(8'h88, 1'b1, 1'b0);
    ecase(8'h98, 1'b0, 1'b1);
    ecase(8'h90, 1'b0, 1'b0);
    ecase(8'h80, 1'b1, 1'b1);
    $display("enable done");
  endtask : t_enable
  task automatic t_presence;
    host_u.wr(8'h0c, 8'ha0);
    repeat (2) @(negedge sys_clk);
    chk({6'h00, cal, oe}, 8'h01);
    tpres = 1'b1;
    n = 0;
    while (oe !== 1'b0 && n < 4) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 4) begin
      bad_count++;
      $display("[ERR] %0t no hold", $time);
      print_verdict();
    end
    chk({6'h00, bp, cal}, 8'h03);
    n = 0;
    while (oe === 1'b0 && n < HOLD + 10) begin
      @(negedge sys_clk);
      n++;
    end
    chk({7'h00, n >= HOLD - 2 && n <= HOLD + 3}, 8'h01);
    chk({7'h00, po}, 8'h01);
    preq = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({7'h00, po}, 8'h00);
    preq = 1'b1;
    host_u.wr(8'h0c, 8'he0);
    tpres = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk({7'h00, cal}, 8'h01);
    tpres = 1'b1;
    n = 0;
    repeat (6) begin
      @(negedge sys_clk);
      n += int'(oe !== 1'b1);
    end
    chk(8'(n), 8'h00);
    host_u.wr(8'h0c, 8'h80);
    repeat (2) @(negedge sys_clk);
    chk({6'h00, bp, src}, 8'h00);
    ipres = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({6'h00, bp, cal}, 8'h03);
    $display("presence done");
  endtask : t_presence
  task automatic t_usb;
    host_u.wr(8'h0b, 8'h00);
    usb_valid = 1'b0;
    host_u.wr(8'h0b, 8'h55);
    host_u.rd(8'h0b, d, ok);
    chk({7'h00, ok}, 8'h00);
    usb_valid = 1'b1;
    rchk(8'h0b, 8'h6b);
    rchk(8'h0c, 8'h94);
    $display("usb done");
  endtask : t_usb
  initial begin
    reset = 1'b1;
    usb_valid = 1'b1;
    pin = 1'b1;
    ipres = 1'b0;
    tpres = 1'b0;
    preq = 1'b1;
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    t_defaults();
    t_fields();
    t_enable();
    t_presence();
    t_usb();
    print_verdict();
  end
endmodule : testbench
